/* File: test/power_sleep_ctl_tb.sv */
// Self-checking testbench of the always-on sleep power controller
`default_nettype none
module power_sleep_ctl_tb
  import sleep_ctl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // Clock, reset and oscillator
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic oscIn = 1'b0;
  logic oscOut;
  // Regulator wire
  logic regOffOut, regOffOeN, regOffIn;
  // Pins and control levels
  logic resumeN = 1'b1, batteryLowIn = 1'b0, hostPorN;
  logic oscEnable = 1'b0, oscSelect = 1'b1, rtcEnable = 1'b1;
  logic pinEn = 1'b0, timedEn = 1'b0, lowDetEn = 1'b0;
  logic lowAbort = 1'b0, sleepReq = 1'b0;
  // Events
  logic [EVT_W-1:0] eventMask = 4'h0, eventClear = 4'h0, rawStatus;
  logic batteryLowFlag, eventIrq;
  // Slow-domain write and readback
  logic wrValid = 1'b0, wrReady, sleeping;
  logic [1:0] wrSel = 2'h0;
  logic [SEC_W-1:0] wrData = 32'h0, secCount, cmp0, cmp1;
  int err_count = 0;
  int cmp_count = 0;

  // 100 MHz system clock
  always #5 clk = ~clk;
  // Free-running oscillator, 8 system cycles a period, edges off clk rise
  always #40 oscIn = ~oscIn;

  // Short counts keep the run brief
  power_sleep_ctl #(.PorCycles(4), .XtalDivide(4)) DUT (
    .clk(clk), .reset_n(reset_n), .osc_in(oscIn), .osc_out(oscOut),
    .regulatorOffIn(regOffIn), .regulatorOffOut(regOffOut),
    .regulatorOffOeN(regOffOeN), .resumeN(resumeN),
    .batteryLowIn(batteryLowIn), .hostPorN(hostPorN),
    .osc_enable(oscEnable), .osc_select(oscSelect), .rtcEnable(rtcEnable),
    .pin_resume_enable(pinEn), .timed_resume_enable(timedEn),
    .battery_low_detect_enable(lowDetEn), .battery_low_abort(lowAbort),
    .sleep_request(sleepReq), .event_mask(eventMask),
    .event_clear(eventClear), .raw_event_status(rawStatus),
    .battery_low_flag(batteryLowFlag), .eventIrq(eventIrq),
    .wrValid(wrValid), .wrSel(wrSel), .wrData(wrData), .wrReady(wrReady),
    .seconds_counter(secCount), .seconds_compare_0(cmp0),
    .seconds_compare_1(cmp1), .sleeping(sleeping));

  // Far side of the regulator-off pin
  regulator_model regModel (.offOut(regOffOut), .offOeN(regOffOeN),
    .wireLevel(regOffIn));

  // Compare one value, count it, report a mismatch
  task automatic check(input string what, input logic [31:0] exp,
      input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // Advance n edges, landing just after the last one
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  // Offer a write and hold it through the edge that takes it
  task automatic wr_issue(input logic [1:0] sel, input logic [31:0] data);
    wrValid = 1'b1;
    wrSel = sel;
    wrData = data;
    // Ready as it stands now is what the coming edge samples
    while (wrReady !== 1'b1) cyc(1);
    cyc(1);
    wrValid = 1'b0;
  endtask : wr_issue

  // Wait, bounded, until the held write has landed
  task automatic wr_done();
    int i;
    for (i = 0; i < 300 && wrReady !== 1'b1; i++) cyc(1);
    check("write completion", 32'h1, {31'h0, wrReady});
    cyc(1);
  endtask : wr_done

  // Spaced write: next access only after wrReady returns
  task automatic write(input logic [1:0] sel, input logic [31:0] data);
    wr_issue(sel, data);
    wr_done();
  endtask : write

  // Bounded wait for the sleeping flag to reach a level
  task automatic wait_sleep(input logic lvl);
    int i;
    for (i = 0; i < 80 && sleeping !== lvl; i++) cyc(1);
  endtask : wait_sleep

  // One-cycle pulses on request and clear inputs
  task automatic pulse_sleep();
    sleepReq = 1'b1;
    cyc(1);
    sleepReq = 1'b0;
  endtask : pulse_sleep

  task automatic clear(input logic [EVT_W-1:0] bits);
    eventClear = bits;
    cyc(1);
    eventClear = 4'h0;
  endtask : clear

  // Print counts and verdict, then stop
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : give_verdict

  // Watchdog far beyond the expected run of some three hundred and ninety cycles
  initial begin
    #300000;
    err_count++;
    give_verdict();
  end

  // Main sequence
  initial begin
    int i;
    cyc(5);
    reset_n = 1'b1;
    cyc(1);
    check("idle pin enable", 32'h1, {31'h0, regOffOeN});
    check("idle host reset", 32'h1, {31'h0, hostPorN});
    check("idle status", 32'h0, {28'h0, rawStatus});
    // No clock source yet: a write must stay held
    wr_issue(WSEL_CMP0, 32'h7);
    cyc(60);
    check("held compare 0", 32'h0, cmp0);
    oscEnable = 1'b1; // oscillator needs no settle wait
    wr_done();
    check("compare 0", 32'h7, cmp0);
    write(WSEL_CMP1, 32'h9);
    write(2'h3, 32'h55);
    check("compare 0 kept", 32'h7, cmp0);
    check("compare 1", 32'h9, cmp1);
    // Matches of each compare, after dropping those of the zero compares
    clear(4'hF);
    write(WSEL_PRELOAD, 32'h7);
    check("counter preload", 32'h7, secCount);
    cyc(20);
    check("match 0", 32'h1, {28'h0, rawStatus});
    write(WSEL_PRELOAD, 32'h9);
    cyc(20);
    check("match 1", 32'h3, {28'h0, rawStatus});
    eventMask = 4'h1;
    cyc(2);
    check("masked irq", 32'h1, {31'h0, eventIrq});
    write(WSEL_PRELOAD, 32'h20);
    clear(4'hF);
    cyc(2);
    check("cleared status", 32'h0, {28'h0, rawStatus});
    check("cleared irq", 32'h0, {31'h0, eventIrq});
    // Battery detection and abort
    eventMask = 4'h4;
    batteryLowIn = 1'b1;
    cyc(20);
    check("flag off", 32'h0, {31'h0, batteryLowFlag});
    check("battery irq off", 32'h0, {31'h0, eventIrq});
    lowDetEn = 1'b1;
    cyc(20);
    check("flag on", 32'h1, {31'h0, batteryLowFlag});
    check("battery irq", 32'h1, {31'h0, eventIrq});
    lowAbort = 1'b1;
    pulse_sleep();
    cyc(40);
    check("abort sleep", 32'h0, {31'h0, sleeping});
    batteryLowIn = 1'b0;
    lowAbort = 1'b0;
    clear(4'hF);
    // Sleep, then pin wake gated by its enable
    pulse_sleep();
    wait_sleep(1'b1);
    check("sleeping", 32'h1, {31'h0, sleeping});
    check("pin driven", 32'h0, {31'h0, regOffIn});
    check("host reset", 32'h0, {31'h0, hostPorN});
    batteryLowIn = 1'b1;
    resumeN = 1'b0;
    cyc(50);
    check("pin gated", 32'h1, {31'h0, sleeping});
    check("no battery test", 32'h0, {31'h0, batteryLowFlag});
    batteryLowIn = 1'b0;
    eventMask = 4'h8;
    pinEn = 1'b1;
    wait_sleep(1'b0);
    check("pin wake", 32'h1, {31'h0, regOffOeN});
    check("powerup reset", 32'h0, {31'h0, hostPorN});
    for (i = 0; i < 12 && hostPorN !== 1'b1; i++) cyc(1);
    check("reset released", 32'h1, {31'h0, hostPorN});
    check("resume event", 32'h1, {31'h0, rawStatus[EVT_RESUME]});
    check("resume irq", 32'h1, {31'h0, eventIrq});
    resumeN = 1'b1;
    cyc(30);
    clear(4'hF);
    // Timed wake
    pinEn = 1'b0;
    timedEn = 1'b1;
    pulse_sleep();
    wait_sleep(1'b1);
    check("sleep again", 32'h1, {31'h0, sleeping});
    write(WSEL_CMP0, 32'h20);
    wait_sleep(1'b0);
    check("timed wake", 32'h0, {31'h0, sleeping});
    check("timed event", 32'h1, {31'h0, rawStatus[EVT_CMP0]});
    // Crystal path: drive output and divided ticks
    oscSelect = 1'b0;
    @(negedge oscIn);
    cyc(3);
    check("crystal drive", 32'h1, {31'h0, oscOut});
    write(WSEL_CMP1, 32'h5);
    check("divided write", 32'h5, cmp1);
    oscSelect = 1'b1;
    @(negedge oscIn);
    cyc(3);
    check("direct drive", 32'h0, {31'h0, oscOut});
    give_verdict();
  end
endmodule : power_sleep_ctl_tb
`default_nettype wire

/* File: test/regulator_model.sv */
// Model of the external regulator enable wire and its pull-up
`default_nettype none
module regulator_model (
  // Open-drain drive from the controller
  input wire logic offOut,
  input wire logic offOeN,
  // Level seen on the wire, fed back to the controller
  output logic wireLevel
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pull-up holds the wire high unless the controller drives it
  assign wireLevel = (offOeN === 1'b0) ? offOut : 1'b1;
endmodule : regulator_model
`default_nettype wire

/* File: verilog/power_sleep_ctl.sv */
// Always-on sleep power controller: regulator control, wake and events
`default_nettype none
module power_sleep_ctl
  import sleep_ctl_pkg::*;
#(
  parameter int unsigned PorCycles = POR_CYCLES,
  parameter int unsigned XtalDivide = XTAL_DIVIDE
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Oscillator pins
  input wire logic osc_in,
  output logic osc_out,
  // Regulator-off open-drain pin, low level only
  input wire logic regulatorOffIn,
  output logic regulatorOffOut,
  output logic regulatorOffOeN,
  // Resume pin, active low
  input wire logic resumeN,
  // Backup supply comparator, high when below threshold
  input wire logic batteryLowIn,
  // Host power-on reset, active low
  output logic hostPorN,
  // Control bits
  input wire logic osc_enable,
  input wire logic osc_select,
  input wire logic rtcEnable,
  input wire logic pin_resume_enable,
  input wire logic timed_resume_enable,
  input wire logic battery_low_detect_enable,
  input wire logic battery_low_abort,
  input wire logic sleep_request,
  // Event mask, clear and status
  input wire logic [EVT_W-1:0] event_mask,
  input wire logic [EVT_W-1:0] event_clear,
  output logic [EVT_W-1:0] raw_event_status,
  output logic battery_low_flag,
  output logic eventIrq,
  // Slow-domain register write
  input wire logic wrValid,
  input wire logic [1:0] wrSel,
  input wire logic [SEC_W-1:0] wrData,
  output logic wrReady,
  // Readback
  output logic [SEC_W-1:0] seconds_counter,
  output logic [SEC_W-1:0] seconds_compare_0,
  output logic [SEC_W-1:0] seconds_compare_1,
  output logic sleeping
);
  // The power-up counter is 32 bits wide
  if (PorCycles < 1) begin : g_bad_por
    $error("PorCycles must be at least 1");
  end

  ref_tick_if tk ();
  // Reference tick generator runs from the selected source once osc_enable is set
  ref_tick_gen #(
    .XtalDivide(XtalDivide)
  ) u_tick (
    .clk(clk),
    .reset_n(reset_n),
    .tk(tk),
    .osc_in(osc_in),
    .osc_out(osc_out)
  );

  assign tk.oscEnable = osc_enable;
  assign tk.oscSelect = osc_select;

  // Power state and its timers
  power_state_t state_q, state_d; // Current power state
  logic [31:0] porCnt_q, porCnt_d; // Cycles since the supply returned
  logic hostPorN_q, hostPorN_d; // Registered host reset
  logic sleepPend_q, sleepPend_d; // Sleep request awaiting a tick
  // Slow-domain registers
  logic [14:0] presc_q, presc_d; // Ticks left in the current second
  logic [SEC_W-1:0] secCnt_q, secCnt_d; // Seconds counter
  logic [SEC_W-1:0] cmp0_q, cmp0_d; // Compare 0
  logic [SEC_W-1:0] cmp1_q, cmp1_d; // Compare 1
  logic wrPend_q, wrPend_d; // Write held until the next tick
  logic [1:0] wrSel_q, wrSel_d; // Target of the held write
  logic [SEC_W-1:0] wrData_q, wrData_d; // Data of the held write
  // Events
  logic resumeSmp_q, resumeSmp_d; // Resume pin sampled on the tick
  logic [EVT_W-1:0] raw_q, raw_d; // Sticky raw event status
  logic irq_q, irq_d; // Registered interrupt request
  // Helpers
  logic match0; // Counter equals compare 0
  logic match1; // Counter equals compare 1
  logic abortSleep; // Low battery vetoes a sleep request
  logic wakeNow; // An enabled wake source fired on this tick
  logic [EVT_W-1:0] evtSet; // Events seen on this tick

  // Compare, abort and wake decode
  always_comb begin
    match0 = rtcEnable && (secCnt_q == cmp0_q);
    match1 = rtcEnable && (secCnt_q == cmp1_q);
    abortSleep = battery_low_detect_enable && battery_low_abort &&
                 batteryLowIn;
    // Pin wake and timed wake each obey their own enable
    wakeNow = (pin_resume_enable && resumeSmp_q) ||
              (timed_resume_enable && (match0 || match1));
  end

  // Power state machine
  always_comb begin
    state_d = state_q;
    porCnt_d = porCnt_q;
    sleepPend_d = sleepPend_q;
    hostPorN_d = hostPorN_q;
    // A request is held and acted on at the next reference tick
    if (sleep_request) begin
      sleepPend_d = 1'b1;
    end
    case (state_q)
      ST_AWAKE: begin
        porCnt_d = '0;
        hostPorN_d = 1'b1;
        if (tk.tick && sleepPend_q) begin
          sleepPend_d = 1'b0;
          // The request is dropped, not deferred, on a weak battery
          if (!abortSleep) begin
            state_d = ST_SLEEP;
            hostPorN_d = 1'b0;
          end
        end
      end
      ST_SLEEP: begin
        // Host is unpowered, so its reset is held throughout
        hostPorN_d = 1'b0;
        sleepPend_d = 1'b0;
        if (tk.tick && wakeNow) begin
          state_d = ST_POWERUP;
        end
      end
      ST_POWERUP: begin
        hostPorN_d = 1'b0;
        sleepPend_d = 1'b0;
        // Only count once the pulled-up line shows the supply back
        if (regulatorOffIn) begin
          if (porCnt_q == PorCycles - 1) begin
            state_d = ST_AWAKE;
            hostPorN_d = 1'b1;
          end else begin
            porCnt_d = porCnt_q + 32'h1;
          end
        end
      end
      default: begin
        state_d = ST_AWAKE;
        hostPorN_d = 1'b1;
      end
    endcase
  end

  // Power state registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_AWAKE;
      porCnt_q <= '0;
      hostPorN_q <= 1'b1;
      sleepPend_q <= 1'b0;
    end else begin
      state_q <= state_d;
      porCnt_q <= porCnt_d;
      hostPorN_q <= hostPorN_d;
      sleepPend_q <= sleepPend_d;
    end
  end

  // Slow-domain writes and the seconds counter
  always_comb begin
    wrPend_d = wrPend_q;
    wrSel_d = wrSel_q;
    wrData_d = wrData_q;
    presc_d = presc_q;
    secCnt_d = secCnt_q;
    cmp0_d = cmp0_q;
    cmp1_d = cmp1_q;
    // Software must space writes; a second one is refused meanwhile
    if (wrValid && !wrPend_q) begin
      wrPend_d = 1'b1;
      wrSel_d = wrSel;
      wrData_d = wrData;
    end
    if (tk.tick) begin
      // Prescaler turns reference ticks into seconds
      if (rtcEnable) begin
        if (presc_q == 15'h0) begin
          presc_d = PRESCALE_RELOAD;
          secCnt_d = secCnt_q + 32'h1;
        end else begin
          presc_d = presc_q - 15'h1;
        end
      end
      // Held write lands on exactly one tick
      if (wrPend_q) begin
        wrPend_d = 1'b0;
        case (wrSel_q)
          WSEL_PRELOAD: begin
            secCnt_d = wrData_q;
            presc_d = PRESCALE_RELOAD;
          end
          WSEL_CMP0: cmp0_d = wrData_q;
          WSEL_CMP1: cmp1_d = wrData_q;
          default: ; // Unused target, write dropped
        endcase
      end
    end
  end

  // Slow-domain registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wrPend_q <= 1'b0;
      wrSel_q <= WSEL_PRELOAD;
      wrData_q <= '0;
      presc_q <= PRESCALE_RELOAD;
      secCnt_q <= '0;
      cmp0_q <= '0;
      cmp1_q <= '0;
    end else begin
      wrPend_q <= wrPend_d;
      wrSel_q <= wrSel_d;
      wrData_q <= wrData_d;
      presc_q <= presc_d;
      secCnt_q <= secCnt_d;
      cmp0_q <= cmp0_d;
      cmp1_q <= cmp1_d;
    end
  end

  // Event capture, sticky status and interrupt
  always_comb begin
    evtSet = '0;
    resumeSmp_d = resumeSmp_q;
    if (tk.tick) begin
      resumeSmp_d = !resumeN;
      evtSet[EVT_CMP0] = match0;
      evtSet[EVT_CMP1] = match1;
      evtSet[EVT_RESUME] = resumeSmp_q;
      // Battery is left alone during sleep
      evtSet[EVT_BATTERY_LOW_FLAG] = battery_low_detect_enable && batteryLowIn &&
                           (state_q != ST_SLEEP);
    end
    // A set in the same cycle as its clear wins
    raw_d = (raw_q & ~event_clear) | evtSet;
    irq_d = |(raw_q & event_mask);
  end

  // Event registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      resumeSmp_q <= 1'b0;
      raw_q <= '0;
      irq_q <= 1'b0;
    end else begin
      resumeSmp_q <= resumeSmp_d;
      raw_q <= raw_d;
      irq_q <= irq_d;
    end
  end

  // Pin and readback; all reads are plain register views
  assign regulatorOffOut = 1'b0;
  assign regulatorOffOeN = (state_q != ST_SLEEP);
  assign hostPorN = hostPorN_q;
  assign wrReady = !wrPend_q;
  assign raw_event_status = raw_q;
  assign battery_low_flag = raw_q[EVT_BATTERY_LOW_FLAG];
  assign eventIrq = irq_q;
  assign seconds_counter = secCnt_q;
  assign seconds_compare_0 = cmp0_q;
  assign seconds_compare_1 = cmp1_q;
  assign sleeping = (state_q == ST_SLEEP);

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  a_pin_goes_low: assert property (
    $fell(regulatorOffOeN) |-> $past(tk.tick && sleepPend_q))
    else $error("regulator-off pin fell without a sleep request tick");
  a_pin_wake: assert property (
    state_q == ST_SLEEP && tk.tick && pin_resume_enable && resumeSmp_q
    |=> state_q == ST_POWERUP && regulatorOffOeN)
    else $error("enabled resume pin did not wake");
  a_timed_wake: assert property (
    state_q == ST_SLEEP && tk.tick && timed_resume_enable && match0
    |=> state_q == ST_POWERUP)
    else $error("enabled compare match did not wake");
  a_wake_gated: assert property (
    state_q == ST_SLEEP && tk.tick && !pin_resume_enable &&
    !timed_resume_enable |=> state_q == ST_SLEEP)
    else $error("woke with no wake source enabled");
  a_por_release: assert property (
    $rose(hostPorN) |-> $past(state_q) == ST_POWERUP && $past(regulatorOffIn))
    else $error("host reset released without supply return");
  a_sleep_abort: assert property (
    state_q == ST_AWAKE && tk.tick && sleepPend_q && abortSleep
    |=> state_q == ST_AWAKE && !sleepPend_q)
    else $error("sleep entered despite low battery abort");
  a_battery_low_flag_set: assert property (
    tk.tick && battery_low_detect_enable && batteryLowIn &&
    state_q != ST_SLEEP |=> battery_low_flag)
    else $error("low battery flag not set");
  a_no_batt_sleep: assert property (
    state_q == ST_SLEEP && !event_clear[EVT_BATTERY_LOW_FLAG] |=>
    raw_q[EVT_BATTERY_LOW_FLAG] == $past(raw_q[EVT_BATTERY_LOW_FLAG]))
    else $error("battery evaluated during sleep");
  a_irq_or: assert property (
    1'b1 |=> eventIrq == |($past(raw_q) & $past(event_mask)))
    else $error("interrupt does not follow masked status");
  a_write_once: assert property (
    wrPend_q && tk.tick |=> wrReady ##1 (!wrPend_q || $past(wrValid)))
    else $error("held write not applied on the tick");
endmodule : power_sleep_ctl
`default_nettype wire

/* File: verilog/ref_tick_gen.sv */
// Reference tick generator: oscillator edge detect and crystal divider
`default_nettype none
module ref_tick_gen
  import sleep_ctl_pkg::*;
#(
  parameter int unsigned XtalDivide = XTAL_DIVIDE
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Tick carrier
  ref_tick_if.gen tk,
  // Oscillator pins
  input wire logic osc_in,
  output logic osc_out
);
  localparam int unsigned DW = $clog2(XtalDivide);

  // The divider wraps naturally, so only powers of two are served
  if (XtalDivide < 2 || (XtalDivide & (XtalDivide - 1)) != 0) begin : g_bad
    $error("XtalDivide must be a power of two of at least 2");
  end

  logic oscPrev_q, oscPrev_d; // Last sampled input level
  logic [DW-1:0] divCnt_q, divCnt_d; // Crystal edge counter
  logic tick_q, tick_d; // Registered reference tick
  logic oscOut_q, oscOut_d; // Crystal drive level
  logic risingEdge; // Input rose this cycle

  // Next-state logic of the divider and the crystal drive
  always_comb begin
    risingEdge = osc_in & ~oscPrev_q;
    oscPrev_d = osc_in;
    divCnt_d = divCnt_q;
    tick_d = 1'b0;
    oscOut_d = 1'b0;
    if (!tk.oscEnable) begin // Source stays dead until enabled
      divCnt_d = '0;
    end else if (tk.oscSelect) begin // Direct reference input
      tick_d = risingEdge;
      divCnt_d = '0;
    end else begin // Crystal path divided down
      oscOut_d = ~osc_in;
      if (risingEdge) begin
        divCnt_d = divCnt_q + 1'b1;
        tick_d = (divCnt_q == DW'(XtalDivide - 1));
      end
    end
  end

  // Register stage only
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      oscPrev_q <= 1'b0;
      divCnt_q <= '0;
      tick_q <= 1'b0;
      oscOut_q <= 1'b0;
    end else begin
      oscPrev_q <= oscPrev_d;
      divCnt_q <= divCnt_d;
      tick_q <= tick_d;
      oscOut_q <= oscOut_d;
    end
  end

  assign tk.tick = tick_q;
  assign osc_out = oscOut_q;

  // A source disabled in this cycle and the one before never ticks
  a_osc_disabled: assert property (@(posedge clk) disable iff (!reset_n)
    !tk.oscEnable ##1 !tk.oscEnable |-> !tk.tick)
    else $error("reference ticked while the source was disabled");
endmodule : ref_tick_gen
`default_nettype wire

/* File: verilog/ref_tick_if.sv */
// Carrier between the controller and its reference tick generator
`default_nettype none
interface ref_tick_if;
  logic oscEnable; // Oscillator or crystal path enabled
  logic oscSelect; // 1 takes the input directly, 0 divides it
  logic tick; // One-cycle pulse per reference period
  modport gen (input oscEnable, input oscSelect, output tick);
  modport sink (output oscEnable, output oscSelect, input tick);
endinterface : ref_tick_if
`default_nettype wire

/* File: verilog/sleep_ctl_pkg.sv */
// Shared constants and types of the always-on sleep power controller
`default_nettype none
package sleep_ctl_pkg;
  // System clock period and power-on reset hold time
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned POR_TIME_NS = 100000;
  localparam int unsigned POR_CYCLES =
    (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Divide ratio that turns the crystal rate into the reference rate
  localparam int unsigned XTAL_DIVIDE = 128;
  // Reference ticks per second, minus one, loaded into the prescaler
  localparam logic [14:0] PRESCALE_RELOAD = 15'h7FFF;
  // Seconds counter and compare width
  localparam int unsigned SEC_W = 32;
  // Event bit positions in the raw status, mask and clear vectors
  localparam int unsigned EVT_CMP0 = 0;
  localparam int unsigned EVT_CMP1 = 1;
  localparam int unsigned EVT_BATTERY_LOW_FLAG = 2;
  localparam int unsigned EVT_RESUME = 3;
  localparam int unsigned EVT_W = 4;
  // Targets of a slow-domain register write
  localparam logic [1:0] WSEL_PRELOAD = 2'h0;
  localparam logic [1:0] WSEL_CMP0 = 2'h1;
  localparam logic [1:0] WSEL_CMP1 = 2'h2;
  // Power states of the controller
  typedef enum logic [1:0] {
    ST_AWAKE = 2'b00,
    ST_SLEEP = 2'b01,
    ST_POWERUP = 2'b10
  } power_state_t;
endpackage : sleep_ctl_pkg
`default_nettype wire
